/* File: rtl/dsw_top.sv */
module dsw_top
  import dsw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic smp_valid,
  input wire logic [31:0] smp_data,
  input wire logic smp_last,
  output logic smp_ready,
  input wire logic acq_error,
  output logic mst_valid,
  output logic [31:0] mst_addr,
  output logic [31:0] mst_data,
  input wire logic mst_ready,
  output logic dma_idle,
  output logic irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0] buf_base_q, buf_base_d;     // Software view of buffer base
  logic [31:0] stat_base_q, stat_base_d;   // Status word target
  logic [CNT_W-1:0] len_q, len_d;          // Length of current buffer
  logic wb_en_q, wb_en_d;                  // Status write-back enable
  logic [31:0] prdata_q, prdata_d;         // Registered read data
  logic slverr_q, slverr_d;                // Registered error answer
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;  // Sticky events
  logic [IRQ_W-1:0] irq_en_q, irq_en_d;    // Event enables
  dsw_state_type state_q, state_d;         // Channel state
  logic [31:0] addr_q, addr_d;             // Next data write address
  logic [CNT_W-1:0] cnt_q, cnt_d;          // Bytes moved into this buffer
  logic [2:0] term_q, term_d;              // Reasons gathered so far
  logic err_pend_q, err_pend_d;            // Fault seen, not yet acted on
  logic last_q, last_d;                    // Beat in flight closes the block
  logic mvalid_q, mvalid_d;                // Memory write request
  logic [31:0] maddr_q, maddr_d;           // Memory write address
  logic [31:0] mword_q, mword_d;           // Memory write value
  logic [IRQ_W-1:0] ev_set;                // Events raised this cycle
  logic acc_wr;                            // Write access phase
  logic setup_rd;                          // Read setup cycle
  logic start;                             // Accepted length write
  logic [CNT_W-1:0] cnt_next;              // Count after current beat
  logic buf_full;                          // Current beat leaves under one beat of room

  // ---------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------
  // Zero wait states: read data is prepared in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slverr_q & psel & penable;
  assign acc_wr = psel & penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  // Length writes outside idle are dropped silently
  assign start = acc_wr && (paddr == OFS_BUF_LEN) && (state_q == DSW_IDLE);

  // ---------------------------------------------------------------
  // Register file, next values
  // ---------------------------------------------------------------
  always_comb
  begin
    buf_base_d = buf_base_q;
    stat_base_d = stat_base_q;
    len_d = len_q;
    wb_en_d = wb_en_q;
    irq_en_d = irq_en_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    // Writes take effect in the access phase
    if (acc_wr)
    begin
      if (paddr == OFS_BUF_BASE)
      begin
        buf_base_d = pwdata;
      end
      else if (paddr == OFS_BUF_LEN)
      begin
        if (start)
        begin
          len_d = pwdata[CNT_W-1:0];
        end
      end
      else if (paddr == OFS_STAT_BASE)
      begin
        stat_base_d = pwdata;
      end
      else if (paddr == OFS_CTRL)
      begin
        wb_en_d = pwdata[CTRL_WB_EN];
      end
      else if (paddr == OFS_IRQ_EN)
      begin
        irq_en_d = pwdata[IRQ_W-1:0];
      end
    end
    // Error flag decided at setup, for reads and writes alike
    if (psel && !penable)
    begin
      slverr_d = !((paddr == OFS_BUF_BASE) || (paddr == OFS_BUF_LEN)
        || (paddr == OFS_NEXT_ADDR) || (paddr == OFS_STAT_BASE)
        || (paddr == OFS_CTRL) || (paddr == OFS_STATE)
        || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_EN)
        || (paddr == OFS_IRQ_CLR));
    end
    // Read data; unmapped and write-only locations read zero
    if (setup_rd)
    begin
      prdata_d = RST_WORD;
      if (paddr == OFS_BUF_BASE)
      begin
        prdata_d = buf_base_q;
      end
      else if (paddr == OFS_BUF_LEN)
      begin
        prdata_d[CNT_W-1:0] = len_q;
      end
      else if (paddr == OFS_NEXT_ADDR)
      begin
        prdata_d = addr_q;
      end
      else if (paddr == OFS_STAT_BASE)
      begin
        prdata_d = stat_base_q;
      end
      else if (paddr == OFS_CTRL)
      begin
        prdata_d[CTRL_WB_EN] = wb_en_q;
      end
      else if (paddr == OFS_STATE)
      begin
        prdata_d[STATE_IDLE] = (state_q == DSW_IDLE);
      end
      else if (paddr == OFS_IRQ_STAT)
      begin
        prdata_d[IRQ_W-1:0] = irq_stat_q;
      end
      else if (paddr == OFS_IRQ_EN)
      begin
        prdata_d[IRQ_W-1:0] = irq_en_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register file, storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_base_q <= RST_WORD;
      stat_base_q <= RST_WORD;
      len_q <= '0;
      wb_en_q <= 1'b0;
      irq_en_q <= '0;
      prdata_q <= RST_WORD;
      slverr_q <= 1'b0;
    end
    else
    begin
      buf_base_q <= buf_base_d;
      stat_base_q <= stat_base_d;
      len_q <= len_d;
      wb_en_q <= wb_en_d;
      irq_en_q <= irq_en_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // ---------------------------------------------------------------
  // Transfer engine, next values
  // ---------------------------------------------------------------
  assign cnt_next = cnt_q + BEAT_BYTES;
  // A fault in the same cycle must not swallow a beat that is never written
  assign smp_ready = (state_q == DSW_XFER) && !err_pend_q && !acq_error;
  // First term guards the subtraction against wrap on short or zero lengths
  assign buf_full = (cnt_next >= len_q) || ((len_q - cnt_next) < BEAT_BYTES);

  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    term_d = term_q;
    err_pend_d = err_pend_q | (acq_error && (state_q != DSW_IDLE));
    last_d = last_q;
    mvalid_d = mvalid_q;
    maddr_d = maddr_q;
    mword_d = mword_q;
    ev_set = '0;
    case (state_q)
      DSW_IDLE:
      begin
        // Base is taken now; later writes to it do not disturb the run
        if (start)
        begin
          addr_d = buf_base_q;
          cnt_d = '0;
          term_d = '0;
          err_pend_d = 1'b0;
          state_d = DSW_XFER;
        end
      end
      DSW_XFER:
      begin
        if (err_pend_q || acq_error)
        begin
          // Fault stops the buffer before the block completes
          term_d[TERM_ERR-TERM_BUF] = 1'b1;
          ev_set[IRQ_ERR] = 1'b1;
          state_d = DSW_SWR;
        end
        else if (smp_valid)
        begin
          last_d = smp_last;
          mvalid_d = 1'b1;
          maddr_d = addr_q;
          mword_d = smp_data;
          state_d = DSW_DWR;
        end
      end
      DSW_DWR:
      begin
        if (mst_ready)
        begin
          mvalid_d = 1'b0;
          addr_d = addr_q + BEAT_ADDR;
          cnt_d = cnt_next;
          // Reasons may combine; a fault during the beat joins them
          term_d[TERM_BLK-TERM_BUF] = last_q;
          term_d[TERM_BUF-TERM_BUF] = buf_full;
          term_d[TERM_ERR-TERM_BUF] = err_pend_q | acq_error;
          if (last_q || buf_full || err_pend_q || acq_error)
          begin
            ev_set[IRQ_ERR] = err_pend_q | acq_error;
            state_d = DSW_SWR;
          end
          else
          begin
            state_d = DSW_XFER;
          end
        end
      end
      DSW_SWR:
      begin
        // A status write in flight finishes even if the enable drops
        if (mvalid_q)
        begin
          if (mst_ready)
          begin
            mvalid_d = 1'b0;
            ev_set[IRQ_DONE] = 1'b1;
            // A full buffer needs a fresh length write to go on
            state_d = DSW_IDLE;
          end
        end
        else if (!wb_en_q)
        begin
          // Without write-back the buffer just terminates
          ev_set[IRQ_DONE] = 1'b1;
          state_d = DSW_IDLE;
        end
        else
        begin
          mvalid_d = 1'b1;
          maddr_d = stat_base_q;
          mword_d = {1'b0, term_q, cnt_q};
        end
      end
      default:
      begin
        state_d = DSW_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Transfer engine, storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= DSW_IDLE;
      addr_q <= RST_WORD;
      cnt_q <= '0;
      term_q <= '0;
      err_pend_q <= 1'b0;
      last_q <= 1'b0;
      mvalid_q <= 1'b0;
      maddr_q <= RST_WORD;
      mword_q <= RST_WORD;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      term_q <= term_d;
      err_pend_q <= err_pend_d;
      last_q <= last_d;
      mvalid_q <= mvalid_d;
      maddr_q <= maddr_d;
      mword_q <= mword_d;
    end
  end

  // ---------------------------------------------------------------
  // Memory write port
  // ---------------------------------------------------------------
  // Request, address and value stay put until mst_ready
  assign mst_valid = mvalid_q;
  assign mst_addr = maddr_q;
  assign dma_idle = (state_q == DSW_IDLE);

  dsw_le_pack #(
    .NBYTES(4)
  ) u_pack (
    .word(mword_q),
    .lanes(mst_data)
  );

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  // A clear in the same cycle as a new event loses: set wins
  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (acc_wr && (paddr == OFS_IRQ_CLR))
    begin
      irq_stat_d = irq_stat_q & ~pwdata[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | ev_set;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat_q <= '0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Level output while any enabled event is pending
  assign irq = |(irq_stat_q & irq_en_q);

endmodule

/* File: rtl/dsw_pkg.sv */
package dsw_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_BUF_BASE = 12'h140;  // Data buffer base
  localparam logic [ADDR_W-1:0] OFS_BUF_LEN = 12'h144;   // Buffer length, starts a transfer
  localparam logic [ADDR_W-1:0] OFS_NEXT_ADDR = 12'h148; // Next data write address
  localparam logic [ADDR_W-1:0] OFS_STAT_BASE = 12'h14C; // Status word target address
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h180;      // Write-back enable
  localparam logic [ADDR_W-1:0] OFS_STATE = 12'h184;     // Channel state
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h188;  // Sticky events
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h18C;    // Event enables
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h190;   // Write one to clear

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int CNT_W = 28;                 // Byte count and length width
  localparam int TERM_ERR = 30;              // Error reason bit
  localparam int TERM_BLK = 29;              // Block or frame end reason bit
  localparam int TERM_BUF = 28;              // Buffer end reason bit
  localparam int CTRL_WB_EN = 0;             // Status write-back enable
  localparam int STATE_IDLE = 0;             // Write channel idle
  localparam int IRQ_W = 2;                  // Number of events
  localparam int IRQ_DONE = 0;               // Buffer terminated
  localparam int IRQ_ERR = 1;                // Buffer ended by error
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [CNT_W-1:0] BEAT_BYTES = 28'h0000004;  // Bytes per data beat
  localparam logic [31:0] BEAT_ADDR = 32'h00000004;       // Address step per beat

  // ---------------------------------------------------------------
  // Channel states, Gray along the usual path
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    DSW_IDLE = 2'b00,
    DSW_XFER = 2'b01,
    DSW_DWR = 2'b11,
    DSW_SWR = 2'b10
  } dsw_state_type;

endpackage

/* File: rtl/dsw_le_pack.sv */
// Places a word on the byte lanes of the memory bus, lowest byte first
module dsw_le_pack
  import dsw_pkg::*;
#(
  parameter int NBYTES = 4
)
(
  input wire logic [8*NBYTES-1:0] word,
  output logic [8*NBYTES-1:0] lanes
);

  // ---------------------------------------------------------------
  // Lane mapping
  // ---------------------------------------------------------------
  // Byte i of the value goes to lane i: little-endian in host memory
  for (genvar i = 0; i < NBYTES; i++)
  begin : g_lane
    assign lanes[8*i +: 8] = word[8*i +: 8];
  end

endmodule

/* File: tb/dsw_properties.sv */
module dsw_properties
  import dsw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic smp_valid,
  input wire logic [31:0] smp_data,
  input wire logic smp_ready,
  input wire logic mst_valid,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_data,
  input wire logic mst_ready,
  input wire logic dma_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------
  // Port relations
  // ----------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Sample word taken from the stream
  sequence beat_take;
    smp_valid && smp_ready;
  endsequence
  // Length write accepted while idle
  sequence len_start;
    psel && penable && pwrite && paddr == OFS_BUF_LEN && dma_idle;
  endsequence
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  a_len_start: assert property (len_start |=> !dma_idle)
    else $error("length write did not start channel");
  a_idle_stream: assert property (smp_ready |-> !dma_idle)
    else $error("stream ready while idle");
  a_one_beat: assert property (beat_take |=> !smp_ready)
    else $error("second beat taken while one in flight");
  a_beat_lanes: assert property (beat_take |=> mst_valid && mst_data == $past(smp_data))
    else $error("memory write does not carry sample");
  a_write_hold: assert property (mst_valid && !mst_ready |=>
    mst_valid && $stable(mst_addr) && $stable(mst_data))
    else $error("memory request changed before accept");
  a_ack_gap: assert property (mst_valid && mst_ready |=> !mst_valid)
    else $error("memory request right after accept");
  a_idle_quiet: assert property (dma_idle |-> !mst_valid && !smp_ready)
    else $error("activity while idle");
endmodule

bind dsw_top dsw_properties chk (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .smp_valid, .smp_data, .smp_ready, .mst_valid, .mst_addr, .mst_data, .mst_ready,
  .dma_idle);

/* File: tb/dsw_host_mem.sv */
// Host memory, byte wide, answering at once or after a stall
module dsw_host_mem
(
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic mst_valid,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_data,
  output logic mst_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [31:0]]; // Sparse byte store
  int n_wr = 0; // Accepted writes
  logic [1:0] wait_q = 2'h0; // Stall cycles so far
  // Ready only with a request, so a released line reads low
  assign mst_ready = mst_valid && (!slow || wait_q == 2'h2);
  // Store lanes lowest byte first
  always @(posedge clk_sys)
  begin
    wait_q <= (mst_valid && !mst_ready) ? wait_q + 2'h1 : 2'h0;
    if (mst_valid && mst_ready)
    begin
      for (int i = 0; i < 4; i++)
        mem[mst_addr + 32'(i)] = mst_data[8*i +: 8];
      n_wr++;
    end
  end
  function automatic logic [31:0] rd32(input logic [31:0] a);
    return {mem[a + 32'h3], mem[a + 32'h2], mem[a + 32'h1], mem[a]};
  endfunction
endmodule

/* File: tb/dsw_status_writeback_tb.sv */
module dsw_status_writeback_tb
  import dsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------
  // Stimulus, device and host memory
  // ----------------------------------------------
  logic clk_sys, nrst, psel, penable, pwrite, slow;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, smp_data, prdata, mst_addr, mst_data, rv;
  logic pready, pslverr, smp_valid, smp_last, smp_ready, acq_error, ev;
  logic mst_valid, mst_ready, dma_idle, irq;
  int err_count = 0, n_compared = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  dsw_top uut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .smp_valid, .smp_data, .smp_last, .smp_ready, .acq_error, .mst_valid,
    .mst_addr, .mst_data, .mst_ready, .dma_idle, .irq);
  dsw_host_mem host (.clk_sys, .slow, .mst_valid, .mst_addr, .mst_data, .mst_ready);
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; answer kept in rv and ev
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic rd;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Answer taken at the very edge where pready is seen high
    do
    begin
      @(posedge clk_sys);
      rd = pready;
      rv = prdata;
      ev = pslverr;
    end
    while (rd !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One sample word, held until taken
  task automatic beat(input logic [31:0] d, input logic l);
    logic rd;
    @(posedge clk_sys);
    smp_valid <= 1'b1;
    smp_data <= d;
    smp_last <= l;
    do
    begin
      @(posedge clk_sys);
      rd = smp_ready;
    end
    while (rd !== 1'b1);
    smp_valid <= 1'b0;
  endtask
  task automatic start(input logic [31:0] b, input logic [31:0] l);
    apb(1'b1, OFS_BUF_BASE, b);
    apb(1'b1, OFS_BUF_LEN, l);
  endtask
  task automatic fault();
    @(posedge clk_sys);
    acq_error <= 1'b1;
    @(posedge clk_sys);
    acq_error <= 1'b0;
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge clk_sys);
    while (dma_idle !== 1'b1) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Clear both events and check irq drops
  task automatic clear_irq();
    apb(1'b1, OFS_IRQ_CLR, 32'h3);
    // Clear lands at the access edge; look once it has settled
    @(negedge clk_sys);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b0, OFS_STAT_BASE, 32'h0);
    chk("stat base reset", rv, 32'h0);
    apb(1'b1, OFS_STAT_BASE, 32'h2000);
    apb(1'b0, OFS_STAT_BASE, 32'h0);
    chk("stat base rw", rv, 32'h2000);
    apb(1'b0, 12'h1F0, 32'h0);
    chk("unmapped error", {31'h0, ev}, 32'h1);
    chk("unmapped data", rv, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h3);
  endtask
  // Full buffer that also ends the block, slow memory, base moved
  task automatic t_buf_end();
    slow <= 1'b1;
    start(32'h1000, 32'h8);
    apb(1'b1, OFS_BUF_BASE, 32'h5000);
    beat(32'h11223344, 1'b0);
    beat(32'h55667788, 1'b1);
    wait_idle();
    chk("data word 0", host.rd32(32'h1000), 32'h11223344);
    chk("data word 1", host.rd32(32'h1004), 32'h55667788);
    chk("status full", host.rd32(32'h2000), 32'h30000008);
    chk("status low byte", {24'h0, host.mem[32'h2000]}, 32'h8);
    chk("done irq", {31'h0, irq}, 32'h1);
    clear_irq();
    slow <= 1'b0;
  endtask
  // Block end, with a length rewrite while busy
  task automatic t_blk_end();
    start(32'h3000, 32'h100);
    apb(1'b1, OFS_BUF_LEN, 32'h4);
    beat(32'hA5A50001, 1'b1);
    wait_idle();
    chk("status block", host.rd32(32'h2000), 32'h20000004);
    chk("block data", host.rd32(32'h3000), 32'hA5A50001);
    clear_irq();
  endtask
  // Fault before any sample moved
  task automatic t_error();
    start(32'h4000, 32'h100);
    fault();
    wait_idle();
    chk("status error", host.rd32(32'h2000), 32'h40000000);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("error events", rv, 32'h3);
    clear_irq();
  endtask
  // Write-back off: buffer ends with no memory write
  task automatic t_no_wb();
    int n;
    apb(1'b1, OFS_CTRL, 32'h0);
    n = host.n_wr;
    start(32'h6000, 32'h100);
    fault();
    wait_idle();
    chk("no status write", 32'(host.n_wr), 32'(n));
    chk("done without write", {31'h0, irq}, 32'h1);
  endtask
  initial
  begin
    // Idle levels at time zero, reset asserted
    clk_sys = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    slow = 1'b0;
    paddr = '0;
    pwdata = '0;
    smp_data = '0;
    smp_valid = 1'b0;
    smp_last = 1'b0;
    acq_error = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_buf_end();
    t_blk_end();
    t_error();
    t_no_wb();
    complete_run();
  end
endmodule
